// ===== hdl/uim_pkg.sv
// Constants shared by the universal input register map.
package uim_pkg;

  // Register spaces of a host request.
  typedef enum logic [1:0] {
    SPACE_STATUS = 2'h0,
    SPACE_INPUT = 2'h1,
    SPACE_HOLDING = 2'h2
  } space_t;

  // Sensor family decoded from a mode code.
  typedef enum logic [2:0] {
    KIND_RAW = 3'h0,
    KIND_CURRENT = 3'h1,
    KIND_VOLTAGE = 3'h2,
    KIND_MILLIVOLT = 3'h3,
    KIND_RESISTANCE = 3'h4,
    KIND_THERMOCOUPLE = 3'h5,
    KIND_RTD = 3'h6,
    KIND_THERMISTOR = 3'h7
  } kind_t;

  localparam int CH_MAX = 12;
  localparam int CH_8 = 8;
  localparam int CH_12 = 12;

  // Status bit addresses.
  localparam logic [15:0] STAT_FIRST = 16'h0001;

  // Input register addresses.
  localparam logic [15:0] IN_PRI_FIRST = 16'h0001;
  localparam logic [15:0] IN_ALT_FIRST_8 = 16'h0009;
  localparam logic [15:0] IN_CJ_FIRST_8 = 16'h0011;
  localparam logic [15:0] IN_CJ_FIRST_12 = 16'h000D;

  // Holding register addresses.
  localparam logic [15:0] HR_TOT_FIRST = 16'h0001;
  localparam logic [15:0] HR_TOT_LAST_8 = 16'h0010;
  localparam logic [15:0] HR_TOT_LAST_12 = 16'h0018;
  localparam logic [15:0] HR_MV_AVG = 16'h0082;
  localparam logic [15:0] HR_LINE_FILTER = 16'h0083;
  localparam logic [15:0] HR_SAMPLE = 16'h0084;
  localparam logic [15:0] HR_MODE_FIRST = 16'h0085;
  localparam logic [15:0] HR_MODE_LAST_8 = 16'h0094;
  localparam logic [15:0] HR_MODE_LAST_12 = 16'h0090;
  localparam logic [15:0] HR_SUPPLY_CAL = 16'h0095;
  localparam logic [15:0] HR_CAL_FIRST = 16'h0096;
  localparam logic [15:0] HR_CAL_LAST_8 = 16'h00BD;
  localparam logic [15:0] HR_CAL_LAST_12 = 16'h00B3;

  localparam int TOT_REGS = 24;
  localparam int MODE_REGS = 16;
  localparam int CAL_REGS = 40;

  // Mode codes.
  localparam logic [15:0] MODE_RESISTANCE = 16'h0004;
  localparam logic [15:0] MODE_TC_FIRST = 16'h0005;
  localparam logic [15:0] MODE_TC_LAST = 16'h0014;
  localparam logic [15:0] MODE_RTD_LAST = 16'h0019;
  localparam logic [15:0] MODE_PAIR_FLIP = 16'h0016;
  localparam logic [15:0] MODE_LAST = 16'h001D;

  // Reset values.
  localparam logic [15:0] REG_RESET = 16'h0000;

  // Exception codes.
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] EXC_ADDRESS = 8'h02;
  localparam logic [7:0] EXC_VALUE = 8'h03;

  // Contact settling time.
  localparam int CLK_HZ = 10_000_000;
  localparam int SETTLE_TIME_MS = 250;
  localparam int SETTLE_CYCLES = SETTLE_TIME_MS * (CLK_HZ / 1000);
  localparam int SETTLE_CNT_W = 22;

  // Decodes a mode code into its sensor family.
  function automatic kind_t mode_kind(input logic [15:0] code);
    if (code < MODE_TC_FIRST) begin
      mode_kind = kind_t'(code[2:0]);
    end else if (code <= MODE_TC_LAST) begin
      mode_kind = KIND_THERMOCOUPLE;
    end else if (code <= MODE_RTD_LAST) begin
      mode_kind = KIND_RTD;
    end else begin
      mode_kind = KIND_THERMISTOR;
    end
  endfunction : mode_kind

  // Fahrenheit codes are even up to the repeated code, odd above it.
  function automatic logic mode_fahr(input logic [15:0] code);
    if (code < MODE_TC_FIRST) begin
      mode_fahr = 1'b0;
    end else if (code <= MODE_PAIR_FLIP) begin
      mode_fahr = ~code[0];
    end else begin
      mode_fahr = code[0];
    end
  endfunction : mode_fahr

endpackage : uim_pkg

// ===== hdl/universal_input_register_map.sv
// Register map and contact input logic of the universal input module.
`timescale 1ns/10ps
`default_nettype none

module universal_input_register_map
  import uim_pkg::*;
#(
  parameter bit TWELVE_CH = 1'b0,
  parameter int SETTLE = SETTLE_CYCLES
) (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic [CH_MAX-1:0] i_contact_high,
  input wire logic [CH_MAX*16-1:0] i_primary_reading,
  input wire logic [CH_8*16-1:0] i_alternate_reading,
  input wire logic [31:0] i_cold_junction,
  input wire logic [CH_MAX-1:0] i_force_en,
  input wire logic [CH_MAX*16-1:0] i_force_value,
  input wire logic i_req,
  input wire logic [1:0] i_space,
  input wire logic i_write,
  input wire logic [15:0] i_addr,
  input wire logic [15:0] i_wdata,
  output logic o_ack,
  output logic [15:0] o_rdata,
  output logic o_exception,
  output logic [7:0] o_exception_code,
  output logic [CH_MAX-1:0] o_contact_on,
  output logic [15:0] o_mv_avg,
  output logic [15:0] o_line_filter,
  output logic [15:0] o_sample_interval,
  output logic [CH_MAX*3-1:0] o_sensor_kind,
  output logic [CH_MAX-1:0] o_fahrenheit
);

  localparam logic [15:0] NCH = TWELVE_CH ? 16'(CH_12) : 16'(CH_8);
  localparam logic [15:0] TOT_LAST = TWELVE_CH ? HR_TOT_LAST_12
                                               : HR_TOT_LAST_8;
  localparam logic [15:0] MODE_LAST_A = TWELVE_CH ? HR_MODE_LAST_12
                                                  : HR_MODE_LAST_8;
  localparam logic [15:0] CAL_LAST = TWELVE_CH ? HR_CAL_LAST_12
                                               : HR_CAL_LAST_8;
  localparam logic [15:0] CJ_FIRST = TWELVE_CH ? IN_CJ_FIRST_12
                                               : IN_CJ_FIRST_8;
  localparam logic [SETTLE_CNT_W-1:0] SETTLE_MAX =
    SETTLE_CNT_W'(SETTLE - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Contact inputs: synchroniser and settling filter.

  logic [CH_MAX-1:0] sync1_reg;
  logic [CH_MAX-1:0] sync2_reg;
  logic [CH_MAX-1:0] high_reg;
  logic [CH_MAX-1:0] contact_valid;
  logic [SETTLE_CNT_W-1:0] settle_reg [CH_MAX];
  logic [15:0] mode_reg [MODE_REGS];

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      sync1_reg <= '1;
      sync2_reg <= '1;
    end else begin
      sync1_reg <= i_contact_high;
      sync2_reg <= sync1_reg;
    end
  end

  genvar g;
  generate
    for (g = 0; g < CH_MAX; g++) begin : g_contact
      wire differs = sync2_reg[g] != high_reg[g];
      wire settled = differs && settle_reg[g] == SETTLE_MAX;
      always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
          settle_reg[g] <= '0;
          high_reg[g] <= 1'b1;
        end else begin
          settle_reg[g] <= (differs && !settled) ? settle_reg[g] + 1'b1
                                                 : '0;
          high_reg[g] <= settled ? sync2_reg[g] : high_reg[g];
        end
      end
      assign contact_valid[g] = TWELVE_CH ?
        (mode_reg[g] == MODE_RESISTANCE) : (g < CH_8);
      assign o_contact_on[g] = !high_reg[g] && contact_valid[g];
      assign o_sensor_kind[g*3 +: 3] = mode_kind(mode_reg[g]);
      assign o_fahrenheit[g] = mode_fahr(mode_reg[g]);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Address decode.

  wire is_stat = i_space == SPACE_STATUS;
  wire is_in = i_space == SPACE_INPUT;
  wire is_hold = i_space == SPACE_HOLDING;
  wire [15:0] a = i_addr;
  wire stat_hit = is_stat && a >= STAT_FIRST && a < STAT_FIRST + NCH;
  wire pri_hit = is_in && a >= IN_PRI_FIRST && a < IN_PRI_FIRST + NCH;
  wire alt_hit = is_in && !TWELVE_CH && a >= IN_ALT_FIRST_8
    && a < IN_ALT_FIRST_8 + 16'(CH_8);
  wire cj_hit = is_in && (a == CJ_FIRST || a == CJ_FIRST + 16'h0001);
  wire tot_hit = is_hold && a >= HR_TOT_FIRST && a <= TOT_LAST;
  wire avg_hit = is_hold && a == HR_MV_AVG;
  wire filt_hit = is_hold && TWELVE_CH && a == HR_LINE_FILTER;
  wire samp_hit = is_hold && a == HR_SAMPLE;
  wire mode_hit = is_hold && a >= HR_MODE_FIRST
    && a <= MODE_LAST_A;
  wire sup_hit = is_hold && TWELVE_CH && a == HR_SUPPLY_CAL;
  wire cal_hit = is_hold && a >= HR_CAL_FIRST && a <= CAL_LAST;

  wire rd_hit = stat_hit || pri_hit || alt_hit || cj_hit;
  wire hold_hit = tot_hit || avg_hit || filt_hit || samp_hit || mode_hit
    || sup_hit || cal_hit;
  wire any_hit = (rd_hit && !i_write) || hold_hit;
  wire bad_mode = mode_hit && i_write && i_wdata > MODE_LAST;
  wire do_write = i_req && i_write && hold_hit && !bad_mode;

  wire [15:0] pri_off = a - IN_PRI_FIRST;
  wire [15:0] alt_off = a - IN_ALT_FIRST_8;
  wire [15:0] cj_off = a - CJ_FIRST;
  wire [15:0] tot_off = a - HR_TOT_FIRST;
  wire [15:0] mode_off = a - HR_MODE_FIRST;
  wire [15:0] cal_off = a - HR_CAL_FIRST;
  wire [3:0] pidx = pri_off[3:0];
  wire [2:0] aidx = alt_off[2:0];
  wire [4:0] tidx = tot_off[4:0];
  wire [3:0] midx = mode_off[3:0];
  wire [5:0] cidx = cal_off[5:0];

  ////////////////////////////////////////////////////////////////////////////
  // Read data selection.

  wire [15:0] pri_val = i_force_en[pidx] ? i_force_value[{pidx, 4'h0} +: 16]
    : i_primary_reading[{pidx, 4'h0} +: 16];
  wire [15:0] alt_val = i_force_en[aidx]
    ? i_force_value[{1'b0, aidx, 4'h0} +: 16]
    : i_alternate_reading[{aidx, 4'h0} +: 16];
  wire [15:0] cj_val = cj_off[0] ? i_cold_junction[31:16]
    : i_cold_junction[15:0];

  logic [15:0] tot_reg [TOT_REGS];
  logic [15:0] cal_reg [CAL_REGS];
  logic [15:0] supply_reg;
  logic [15:0] avg_reg;
  logic [15:0] filt_reg;
  logic [15:0] samp_reg;

  wire [15:0] rdata_next =
    stat_hit ? {15'h0000, o_contact_on[pri_off[3:0]]} :
    pri_hit ? pri_val :
    alt_hit ? alt_val :
    cj_hit ? cj_val :
    tot_hit ? tot_reg[tidx] :
    avg_hit ? avg_reg :
    filt_hit ? filt_reg :
    samp_hit ? samp_reg :
    mode_hit ? mode_reg[midx] :
    sup_hit ? supply_reg :
    cal_hit ? cal_reg[cidx] : 16'h0000;

  wire [7:0] exc_next = !any_hit ? EXC_ADDRESS :
    bad_mode ? EXC_VALUE : EXC_NONE;

  ////////////////////////////////////////////////////////////////////////////
  // Answer registers.

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      o_ack <= 1'b0;
      o_rdata <= 16'h0000;
      o_exception <= 1'b0;
      o_exception_code <= EXC_NONE;
    end else begin
      o_ack <= i_req;
      o_rdata <= (i_req && !i_write) ? rdata_next : 16'h0000;
      o_exception <= i_req && exc_next != EXC_NONE;
      o_exception_code <= i_req ? exc_next : EXC_NONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Holding registers.

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      for (int i = 0; i < TOT_REGS; i++) tot_reg[i] <= REG_RESET;
      for (int i = 0; i < MODE_REGS; i++) mode_reg[i] <= REG_RESET;
      for (int i = 0; i < CAL_REGS; i++) cal_reg[i] <= REG_RESET;
      supply_reg <= REG_RESET;
      avg_reg <= REG_RESET;
      filt_reg <= REG_RESET;
      samp_reg <= REG_RESET;
    end else if (do_write) begin
      if (tot_hit) tot_reg[tidx] <= i_wdata;
      if (mode_hit) mode_reg[midx] <= i_wdata;
      if (cal_hit) cal_reg[cidx] <= i_wdata;
      if (sup_hit) supply_reg <= i_wdata;
      if (avg_hit) avg_reg <= i_wdata;
      if (filt_hit) filt_reg <= i_wdata;
      if (samp_hit) samp_reg <= i_wdata;
    end
  end

  assign o_mv_avg = avg_reg;
  assign o_line_filter = filt_reg;
  assign o_sample_interval = samp_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  AST_HIGH_IS_OFF: assert property (@(posedge i_core_clk)
    disable iff (i_reset) $rose(high_reg[0])
      |-> $past(sync2_reg[0]) && !o_contact_on[0])
    else $error("Contact above threshold reported ON.");

  AST_LOW_IS_ON: assert property (@(posedge i_core_clk)
    disable iff (i_reset) ($fell(high_reg[0]) && contact_valid[0])
      |-> o_contact_on[0] && !$past(sync2_reg[0]))
    else $error("Contact below threshold not reported ON.");

  AST_MODE_GATES: assert property (@(posedge i_core_clk)
    disable iff (i_reset) (TWELVE_CH && mode_reg[0] != MODE_RESISTANCE)
      |-> !o_contact_on[0])
    else $error("Contact reported outside resistance mode.");

  AST_SETTLE: assert property (@(posedge i_core_clk)
    disable iff (i_reset) $changed(high_reg[0])
      |-> $past(settle_reg[0]) == SETTLE_MAX)
    else $error("Contact changed before settling time.");

  AST_STAT_READ: assert property (@(posedge i_core_clk)
    disable iff (i_reset)
    (i_req && !i_write && is_stat && a == STAT_FIRST)
      |=> o_ack && o_rdata == {15'h0000, $past(o_contact_on[0])})
    else $error("Status bit one read wrong.");

  AST_FORCE: assert property (@(posedge i_core_clk)
    disable iff (i_reset)
    (i_req && !i_write && is_in && a == IN_PRI_FIRST && i_force_en[0])
      |=> o_rdata == $past(i_force_value[15:0]))
    else $error("Forced reading not presented.");

  AST_COLD_JUNCTION: assert property (@(posedge i_core_clk)
    disable iff (i_reset)
    (i_req && !i_write && is_in && a == CJ_FIRST + 16'h0001)
      |=> o_rdata == $past(i_cold_junction[31:16]) && !o_exception)
    else $error("Second cold junction read wrong.");

  AST_AVG_WRITE: assert property (@(posedge i_core_clk)
    disable iff (i_reset)
    (i_req && i_write && is_hold && a == HR_MV_AVG)
      |=> o_mv_avg == $past(i_wdata) ##1 (o_mv_avg == $past(i_wdata, 2)
        || $past(i_req && i_write && avg_hit)))
    else $error("Averaging mode write not stored.");

  AST_BAD_MODE: assert property (@(posedge i_core_clk)
    disable iff (i_reset)
    (i_req && i_write && is_hold && a == HR_MODE_FIRST
      && i_wdata > MODE_LAST)
      |=> o_exception_code == EXC_VALUE && $stable(mode_reg[0]))
    else $error("Illegal mode code accepted.");

  AST_UNMAPPED: assert property (@(posedge i_core_clk)
    disable iff (i_reset) (i_req && a == 16'h0000)
      |=> o_ack && o_exception && o_exception_code == EXC_ADDRESS)
    else $error("Unmapped address not refused.");

endmodule : universal_input_register_map

`default_nettype wire

// ===== bench/uim_host_model.sv
// Host controller model that polls the register map.
`timescale 1ns/10ps
`default_nettype none
module uim_host_model
  import uim_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_ack,
  input wire logic [15:0] i_rdata,
  input wire logic i_exception,
  input wire logic [7:0] i_exception_code,
  output logic o_req,
  output logic [1:0] o_space,
  output logic o_write,
  output logic [15:0] o_addr,
  output logic [15:0] o_wdata
);
  initial begin
    o_req = 1'b0;
    o_space = 2'h3;
    o_write = 1'b0;
    o_addr = 16'h5555;
    o_wdata = 16'haaaa;
  end
  //////////////////////////////////////////////////////////////////////////////
  // One request pulse, then the answer is taken on the next edge.
  task automatic xfer(input space_t sp, input logic wr, input logic [15:0] addr,
                      input logic [15:0] wdata, output logic [15:0] rd,
                      output logic [7:0] code, output logic ex,
                      output logic ok);
    int n;
    ok = 1'b0;
    rd = 16'h0000;
    code = 8'h00;
    ex = 1'b0;
    @(posedge i_core_clk);
    #1;
    o_req = 1'b1;
    o_space = sp;
    o_write = wr;
    o_addr = addr;
    o_wdata = wdata;
    @(posedge i_core_clk);
    #1;
    o_req = 1'b0;
    o_space = ~sp;
    o_write = ~wr;
    o_addr = ~addr;
    o_wdata = ~wdata;
    for (n = 0; n < 4 && !ok; n++) begin
      if (i_ack === 1'b1) begin
        ok = 1'b1;
        rd = i_rdata;
        code = i_exception_code;
        ex = i_exception;
      end else begin
        @(posedge i_core_clk);
        #1;
      end
    end
  endtask : xfer
endmodule : uim_host_model
`default_nettype wire

// ===== bench/tb_top.sv
// Self-checking bench of the twelve-channel register map.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import uim_pkg::*;
  localparam int SET = 8;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [11:0] contact_high, force_en, contact_on, fahrenheit;
  logic [191:0] primary, force_value;
  logic [127:0] alternate = 128'h0;
  logic [31:0] cold_junction = 32'h0155_00fa;
  logic req, wr, ack, exc;
  logic [1:0] sp;
  logic [15:0] addr, wdata, rdata, mv_avg, line_filter, sample_interval;
  logic [7:0] exc_code;
  logic [35:0] sensor_kind;
  logic [2:0] ek;
  int n_mismatch = 0;
  int compares = 0;
  int c;
  always #50 core_clk = ~core_clk;
  universal_input_register_map #(.TWELVE_CH(1'b1), .SETTLE(SET)) i_dut (
    .i_core_clk(core_clk), .i_reset(reset), .i_contact_high(contact_high),
    .i_primary_reading(primary), .i_alternate_reading(alternate),
    .i_cold_junction(cold_junction), .i_force_en(force_en),
    .i_force_value(force_value), .i_req(req), .i_space(sp), .i_write(wr),
    .i_addr(addr), .i_wdata(wdata), .o_ack(ack), .o_rdata(rdata),
    .o_exception(exc), .o_exception_code(exc_code),
    .o_contact_on(contact_on), .o_mv_avg(mv_avg), .o_line_filter(line_filter),
    .o_sample_interval(sample_interval), .o_sensor_kind(sensor_kind),
    .o_fahrenheit(fahrenheit));
  uim_host_model i_host (
    .i_core_clk(core_clk), .i_ack(ack), .i_rdata(rdata), .i_exception(exc),
    .i_exception_code(exc_code), .o_req(req), .o_space(sp), .o_write(wr),
    .o_addr(addr), .o_wdata(wdata));
  //////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic acc(input space_t s, input logic w, input logic [15:0] a,
                     input logic [15:0] d, input logic [15:0] exp_rd,
                     input logic [7:0] exp_code);
    logic [15:0] rd;
    logic [7:0] code;
    logic ex;
    logic ok;
    i_host.xfer(s, w, a, d, rd, code, ex, ok);
    if (ok !== 1'b1) begin
      n_mismatch++;
      print_verdict();
    end else begin
      check(rd, exp_rd);
      check({7'h00, ex, code}, {7'h00, exp_code != 8'h00, exp_code});
    end
  endtask : acc
  task automatic settle(input int cycles);
    repeat (cycles) @(posedge core_clk);
    #1;
  endtask : settle
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    contact_high = 12'hfff;
    force_en = 12'h000;
    for (c = 0; c < 12; c++) begin
      primary[c*16+:16] = 16'h1000 + 16'(c);
      force_value[c*16+:16] = 16'hf000 + 16'(c);
    end
    settle(5);
    reset = 1'b0;
    acc(SPACE_HOLDING, 1'b0, 16'h0082, 16'h0000, 16'h0000, EXC_NONE);
    acc(SPACE_HOLDING, 1'b0, 16'h0083, 16'h0000, 16'h0000, EXC_NONE);
    check({4'h0, contact_on}, 16'h0000);
    $display("test reset done");
    for (c = 0; c < 12; c++) begin
      acc(SPACE_INPUT, 1'b0, 16'(c + 1), 16'h0, 16'h1000 + 16'(c), 8'h00);
    end
    acc(SPACE_INPUT, 1'b0, 16'h000d, 16'h0000, 16'h00fa, EXC_NONE);
    acc(SPACE_INPUT, 1'b0, 16'h000e, 16'h0000, 16'h0155, EXC_NONE);
    acc(SPACE_INPUT, 1'b0, 16'h000f, 16'h0000, 16'h0000, EXC_ADDRESS);
    acc(SPACE_HOLDING, 1'b0, 16'h0000, 16'h0000, 16'h0000, EXC_ADDRESS);
    acc(SPACE_INPUT, 1'b1, 16'h0001, 16'h1234, 16'h0000, EXC_ADDRESS);
    force_en = 12'h009;
    acc(SPACE_INPUT, 1'b0, 16'h0004, 16'h0000, 16'hf003, EXC_NONE);
    acc(SPACE_INPUT, 1'b0, 16'h0001, 16'h0000, 16'hf000, EXC_NONE);
    force_en = 12'h000;
    acc(SPACE_INPUT, 1'b0, 16'h0004, 16'h0000, 16'h1003, EXC_NONE);
    $display("test readings done");
    for (c = 1; c <= 24; c++) begin
      acc(SPACE_HOLDING, 1'b1, 16'(c), 16'ha000 + 16'(c), 16'h0, 8'h00);
    end
    for (c = 1; c <= 24; c++) begin
      acc(SPACE_HOLDING, 1'b0, 16'(c), 16'h0, 16'ha000 + 16'(c), 8'h00);
    end
    acc(SPACE_HOLDING, 1'b1, 16'h0019, 16'h0001, 16'h0000, EXC_ADDRESS);
    acc(SPACE_HOLDING, 1'b1, 16'h0082, 16'h00c3, 16'h0000, EXC_NONE);
    acc(SPACE_HOLDING, 1'b1, 16'h0083, 16'h0a5f, 16'h0000, EXC_NONE);
    acc(SPACE_HOLDING, 1'b1, 16'h0084, 16'h003c, 16'h0000, EXC_NONE);
    acc(SPACE_HOLDING, 1'b1, 16'h0095, 16'hfedc, 16'h0000, EXC_NONE);
    acc(SPACE_HOLDING, 1'b0, 16'h0095, 16'h0000, 16'hfedc, EXC_NONE);
    check(mv_avg, 16'h00c3);
    check(line_filter, 16'h0a5f);
    check(sample_interval, 16'h003c);
    $display("test holding done");
    for (c = 0; c < 30; c++) begin
      acc(SPACE_HOLDING, 1'b1, 16'h0085, 16'(c), 16'h0000, EXC_NONE);
      ek = c < 5 ? 3'(c) : c <= 20 ? 3'h5 : c <= 25 ? 3'h6 : 3'h7;
      check({13'h0, sensor_kind[2:0]}, {13'h0, ek});
      check({15'h0, fahrenheit[0]}, {15'h0, c >= 5 && (c <= 22) == !c[0]});
    end
    acc(SPACE_HOLDING, 1'b1, 16'h0085, 16'h001e, 16'h0000, EXC_VALUE);
    acc(SPACE_HOLDING, 1'b0, 16'h0085, 16'h0000, 16'h001d, EXC_NONE);
    acc(SPACE_HOLDING, 1'b0, 16'h0091, 16'h0000, 16'h0000, EXC_ADDRESS);
    $display("test modes done");
    acc(SPACE_HOLDING, 1'b1, 16'h0085, 16'h0004, 16'h0000, EXC_NONE);
    acc(SPACE_HOLDING, 1'b1, 16'h0086, 16'h0000, 16'h0000, EXC_NONE);
    contact_high = 12'h000;
    settle(3);
    check({15'h0, contact_on[0]}, 16'h0000);
    settle(SET + 4);
    check({14'h0, contact_on[1:0]}, 16'h0001);
    acc(SPACE_STATUS, 1'b0, 16'h0001, 16'h0000, 16'h0001, EXC_NONE);
    acc(SPACE_STATUS, 1'b0, 16'h0002, 16'h0000, 16'h0000, EXC_NONE);
    acc(SPACE_STATUS, 1'b0, 16'h000d, 16'h0000, 16'h0000, EXC_ADDRESS);
    acc(SPACE_STATUS, 1'b1, 16'h0001, 16'h0000, 16'h0000, EXC_ADDRESS);
    contact_high[0] = 1'b1;
    settle(3);
    contact_high[0] = 1'b0;
    settle(SET + 6);
    check({15'h0, contact_on[0]}, 16'h0001);
    contact_high[0] = 1'b1;
    settle(SET + 6);
    check({15'h0, contact_on[0]}, 16'h0000);
    $display("test contacts done");
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
